/* rtl/atrc_pkg.sv */
// constants, types and field layout of the converter trigger and result control block
package atrc_pkg;

   // ----------------------------------------------------------------
   // register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_RESULT_LOW  = 8'h78;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
   localparam logic [7:0] IDX_CTRL_A      = 8'h7a;
   localparam logic [7:0] IDX_CTRL_B      = 8'h7b;
   localparam logic [7:0] IDX_CHAN_REF    = 8'h7c;
   localparam logic [7:0] IDX_PIN_DISABLE = 8'h7e;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int A_ENABLE   = 7;
   localparam int A_START    = 6;
   localparam int A_AUTO     = 5;
   localparam int A_FLAG     = 4;
   localparam int A_IRQ_EN   = 3;
   localparam int M_LEFT     = 5;

   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [9:0] RST_RESULT    = 10'h000;
   localparam logic [4:0] FIRST_CYCLES  = 5'h19;
   localparam logic [4:0] NORMAL_CYCLES = 5'h0d;
   localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
   localparam logic [2:0] DIV_CODE_MIN  = 3'h1;

   typedef enum logic [0:0] {ST_IDLE, ST_CONV} atrc_state_e;

endpackage

/* rtl/atrc_clk_div.sv */
// converter clock divider producing a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module atrc_clk_div
(
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_run,
   input  wire logic [2:0] i_sel,
   output logic            o_tick
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic [6:0] cnt;
      logic       tick;
   } atrc_div_s;

   atrc_div_s st;
   atrc_div_s next_st;
   logic [6:0] limit;

   // codes 0 and 1 both give two, others a power of two
   always_comb
   begin
      if (i_sel <= atrc_pkg::DIV_CODE_MIN)
         limit = 7'h01;
      else
         limit = 7'((8'h01 << i_sel) - 8'h01);
   end

   // counter restarts whenever the converter is idle or off
   always_comb
   begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!i_run)
         next_st.cnt = 7'h00;
      else if (st.cnt >= limit)
      begin
         next_st.cnt = 7'h00;
         next_st.tick = 1'b1;
      end
      else
         next_st.cnt = 7'(st.cnt + 7'h01);
   end

   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         st <= '0;
      else
         st <= next_st;
   end

   assign o_tick = st.tick;

endmodule
`default_nettype wire

/* rtl/atrc_top.sv */
// converter trigger, sequencing, result and register logic behind a wishbone slave
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module atrc_top
(
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   // wishbone classic slave
   input  wire logic       i_wb_cyc,
   input  wire logic       i_wb_stb,
   input  wire logic       i_wb_we,
   input  wire logic [9:0] i_wb_adr,
   input  wire logic [3:0] i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic [31:0]     o_wb_dat,
   output logic            o_wb_ack,
   // trigger flags of sources 1..7, same clock
   input  wire logic [6:0] i_trigger_flags,
   // processor interrupt side
   input  wire logic       i_global_irq_enable,
   input  wire logic       i_irq_vector_ack,
   output logic            o_irq_request,
   // analog converter side
   input  wire logic [9:0] i_conv_result,
   output logic            o_conv_busy,
   output logic            o_conv_clk_en,
   output logic [4:0]      o_input_channel_select,
   output logic [1:0]      o_reference_select,
   // analog pins, raw digital level from the pads
   input  wire logic [7:0] i_pin_raw,
   output logic [7:0]      o_pin_digital_buffer_off,
   output logic [7:0]      o_pin_read
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic                      ack;
      logic [7:0]                rdat;
      logic                      converter_enable;
      logic                      auto_trigger_enable;
      logic                      conversion_done_flag;
      logic                      conversion_done_irq_enable;
      logic [2:0]                converter_clock_divider_select;
      logic [2:0]                trigger_source_select;
      logic [1:0]                reference_select;
      logic                      result_left_align;
      logic [4:0]                input_channel_select;
      logic [7:0]                analog_pin_input_disable;
      atrc_pkg::atrc_state_e     state;
      logic [4:0]                cnt;
      logic                      init_done;
      logic                      lock;
      logic [9:0]                conversion_result;
      logic                      trig_prev;
      logic                      done_evt;
      logic [1:0]                act_ref;
      logic [4:0]                act_chan;
      logic [7:0]                pin_meta;
      logic [7:0]                pin_sync;
      logic [7:0]                pin_read;
   } atrc_state_s;

   atrc_state_s st;
   atrc_state_s next_st;

   logic       tick;
   logic       access;
   logic       wr_a;
   logic       sel_sig;
   logic       trig_edge;
   logic       free_run;
   logic       sw_start;
   logic       finish;
   logic [4:0] target;
   logic [7:0] idx;

   // picks one result byte in the current alignment
   function automatic logic [7:0] fmt_byte(input logic [9:0] r, input logic left,
                                           input logic high);
      logic [7:0] b;
      b = 8'h00;
      if (left)
         b = high ? r[9:2] : {r[1:0], 6'h00};
      else
         b = high ? {6'h00, r[9:8]} : r[7:0];
      return b;
   endfunction

   // ----------------------------------------------------------------
   // converter clock
   // ----------------------------------------------------------------
   atrc_clk_div u_div
   (
      .i_clk  (i_clk),
      .i_rstn (i_rstn),
      .i_run  (st.state == atrc_pkg::ST_CONV),
      .i_sel  (st.converter_clock_divider_select),
      .o_tick (tick)
   );

   // ----------------------------------------------------------------
   // decode and start conditions
   // ----------------------------------------------------------------
   // effects happen at the edge where the master sees ack
   assign idx    = i_wb_adr[9:2];
   assign access = i_wb_cyc && i_wb_stb && st.ack;
   assign wr_a   = access && i_wb_we && i_wb_sel[0] && (idx == atrc_pkg::IDX_CTRL_A);

   // code zero yields no level, so switching to it makes no edge
   always_comb
   begin
      if (st.trigger_source_select == atrc_pkg::TRIG_FREE_RUN)
         sel_sig = 1'b0;
      else
         sel_sig = i_trigger_flags[3'(st.trigger_source_select - 3'h1)];
   end

   // edge against the previously selected level; source change counts
   assign trig_edge = st.auto_trigger_enable && sel_sig && !st.trig_prev;
   // restart right after completion in free running
   assign free_run  = st.auto_trigger_enable && st.done_evt &&
                      (st.trigger_source_select == atrc_pkg::TRIG_FREE_RUN);
   assign sw_start  = wr_a && i_wb_dat[atrc_pkg::A_START] && i_wb_dat[atrc_pkg::A_ENABLE];
   // first conversion after enable runs longer
   assign target    = st.init_done ? atrc_pkg::NORMAL_CYCLES : atrc_pkg::FIRST_CYCLES;
   assign finish    = (st.state == atrc_pkg::ST_CONV) && tick &&
                      (st.cnt == 5'(target - 5'h01)) && st.converter_enable;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      next_st = st;
      next_st.ack = i_wb_cyc && i_wb_stb && !st.ack;
      next_st.done_evt = 1'b0;
      next_st.trig_prev = sel_sig;

      // register read data, unmapped addresses read zero
      if (i_wb_cyc && i_wb_stb && !st.ack)
      begin
         unique case (idx)
            atrc_pkg::IDX_RESULT_LOW:
               next_st.rdat = fmt_byte(st.conversion_result, st.result_left_align, 1'b0);
            atrc_pkg::IDX_RESULT_HIGH:
               next_st.rdat = fmt_byte(st.conversion_result, st.result_left_align, 1'b1);
            atrc_pkg::IDX_CTRL_A:
               next_st.rdat = {st.converter_enable, (st.state == atrc_pkg::ST_CONV),
                               st.auto_trigger_enable, st.conversion_done_flag,
                               st.conversion_done_irq_enable,
                               st.converter_clock_divider_select};
            atrc_pkg::IDX_CTRL_B:
               next_st.rdat = {5'h00, st.trigger_source_select};
            atrc_pkg::IDX_CHAN_REF:
               next_st.rdat = {st.reference_select, st.result_left_align,
                               st.input_channel_select};
            atrc_pkg::IDX_PIN_DISABLE:
               next_st.rdat = st.analog_pin_input_disable;
            default:
               next_st.rdat = atrc_pkg::RST_BYTE;
         endcase
      end

      // result lock follows the read order
      if (access && !i_wb_we && (idx == atrc_pkg::IDX_RESULT_LOW))
         next_st.lock = 1'b1;
      if (access && !i_wb_we && (idx == atrc_pkg::IDX_RESULT_HIGH))
         next_st.lock = 1'b0;

      // register writes, byte lane zero only
      if (access && i_wb_we && i_wb_sel[0])
      begin
         unique case (idx)
            atrc_pkg::IDX_CTRL_A:
            begin
               next_st.converter_enable = i_wb_dat[atrc_pkg::A_ENABLE];
               next_st.auto_trigger_enable = i_wb_dat[atrc_pkg::A_AUTO];
               next_st.conversion_done_irq_enable = i_wb_dat[atrc_pkg::A_IRQ_EN];
               next_st.converter_clock_divider_select = i_wb_dat[2:0];
               if (i_wb_dat[atrc_pkg::A_FLAG])
                  next_st.conversion_done_flag = 1'b0;
            end
            // bits 7 to 3 are reserved and never stored
            atrc_pkg::IDX_CTRL_B:
               next_st.trigger_source_select = i_wb_dat[2:0];
            atrc_pkg::IDX_CHAN_REF:
            begin
               next_st.reference_select = i_wb_dat[7:6];
               next_st.result_left_align = i_wb_dat[atrc_pkg::M_LEFT];
               next_st.input_channel_select = i_wb_dat[4:0];
            end
            atrc_pkg::IDX_PIN_DISABLE:
               next_st.analog_pin_input_disable = i_wb_dat[7:0];
            default:
            begin
            end
         endcase
      end

      // vector acknowledge clears the flag
      if (i_irq_vector_ack)
         next_st.conversion_done_flag = 1'b0;

      // conversion sequencer
      unique case (st.state)
         atrc_pkg::ST_IDLE:
         begin
            // selections only move while idle
            next_st.act_ref = st.reference_select;
            next_st.act_chan = st.input_channel_select;
            next_st.cnt = 5'h00;
            if (sw_start || (st.converter_enable && (trig_edge || free_run)))
            begin
               next_st.state = atrc_pkg::ST_CONV;
               next_st.act_ref = sw_start ? next_st.reference_select : st.reference_select;
               next_st.act_chan = sw_start ? next_st.input_channel_select
                                           : st.input_channel_select;
            end
         end
         atrc_pkg::ST_CONV:
         begin
            if (tick)
               next_st.cnt = 5'(st.cnt + 5'h01);
            if (finish)
            begin
               next_st.state = atrc_pkg::ST_IDLE;
               next_st.init_done = 1'b1;
               next_st.done_evt = 1'b1;
               // a locked result is kept, the new sample is dropped
               if (!next_st.lock)
                  next_st.conversion_result = i_conv_result;
               next_st.conversion_done_flag = 1'b1; // set beats any clear
            end
         end
      endcase

      // disabling aborts and forces the long first conversion again
      if (!next_st.converter_enable)
      begin
         next_st.state = atrc_pkg::ST_IDLE;
         next_st.init_done = 1'b0;
         next_st.cnt = 5'h00;
      end

      // pad levels cross two flops, then masked by the disable bits
      next_st.pin_meta = i_pin_raw;
      next_st.pin_sync = st.pin_meta;
      next_st.pin_read = st.pin_sync & ~st.analog_pin_input_disable;
   end

   // everything clears on reset
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         st <= '0;
      else
         st <= next_st;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_wb_ack = st.ack;
   assign o_wb_dat = {24'h000000, st.rdat};
   // three-way gate on the interrupt request
   assign o_irq_request = st.conversion_done_flag && st.conversion_done_irq_enable &&
                          i_global_irq_enable;
   assign o_conv_busy = (st.state == atrc_pkg::ST_CONV);
   assign o_conv_clk_en = tick && (st.state == atrc_pkg::ST_CONV);
   assign o_input_channel_select = st.act_chan;
   assign o_reference_select = st.act_ref;
   assign o_pin_digital_buffer_off = st.analog_pin_input_disable;
   assign o_pin_read = st.pin_read;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   sequence s_low_read;
      access && !i_wb_we && (idx == atrc_pkg::IDX_RESULT_LOW);
   endsequence

   sequence s_no_high_read;
      !(access && !i_wb_we && (idx == atrc_pkg::IDX_RESULT_HIGH));
   endsequence

   property p_trigger_start;
      (st.state == atrc_pkg::ST_IDLE) && st.converter_enable && trig_edge &&
      !(wr_a && !i_wb_dat[atrc_pkg::A_ENABLE]) |=> o_conv_busy;
   endproperty
   a_trigger_start: assert property (p_trigger_start) else $error("edge did not start");

   property p_flag_set;
      finish |=> st.conversion_done_flag && !o_conv_busy;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set at finish");

   property p_irq_gate;
      o_irq_request |-> st.conversion_done_flag && st.conversion_done_irq_enable &&
                        i_global_irq_enable;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq without flag and enable");

   property p_vector_clear;
      i_irq_vector_ack && !finish |=> !st.conversion_done_flag;
   endproperty
   a_vector_clear: assert property (p_vector_clear) else $error("vector did not clear");

   property p_write_clear;
      wr_a && i_wb_dat[atrc_pkg::A_FLAG] && !finish |=> !st.conversion_done_flag;
   endproperty
   a_write_clear: assert property (p_write_clear) else $error("write one kept flag");

   property p_lock_hold;
      // a high read right after the window may legally release the lock
      s_low_read ##1 s_no_high_read [*3] |->
         ($past(st.conversion_result, 2) == st.conversion_result) ##1
         $stable(st.conversion_result);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked result changed");

   property p_abort;
      wr_a && !i_wb_dat[atrc_pkg::A_ENABLE] |=> !o_conv_busy ##1 !o_conv_busy;
   endproperty
   a_abort: assert property (p_abort) else $error("disable did not abort");

   property p_free_run;
      free_run && st.converter_enable && !wr_a |=> o_conv_busy;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free running did not restart");

   property p_pin_zero;
      1'b1 |=> (o_pin_read & $past(st.analog_pin_input_disable)) == 8'h00;
   endproperty
   a_pin_zero: assert property (p_pin_zero) else $error("disabled pin read one");

   property p_length;
      // divider never ticks twice in a row, so the count stood one cycle
      finish |-> ($past(st.cnt) == 5'(target - 5'h01)) && !$past(tick);
   endproperty
   a_length: assert property (p_length) else $error("conversion length wrong");

endmodule
`default_nettype wire

/* sim/atrc_core_model.sv */
// interrupt acceptance model of the processor core
`timescale 1ns/1ps
`default_nettype none
module atrc_core_model
(
   input  wire logic       i_clk,
   input  wire logic       i_rstn,
   input  wire logic       i_irq_request,
   input  wire logic       i_serve,
   input  wire logic [3:0] i_delay,
   output logic            o_vector_ack
);
   int wait_n;
   // vector taken after a chosen delay, once per request; the count saturates
   // so a request that never drops is not answered twice
   always @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wait_n <= 0;
         o_vector_ack <= 1'h0;
      end
      else
      begin
         o_vector_ack <= 1'h0;
         if (!(i_irq_request && i_serve))
            wait_n <= 0;
         else if (wait_n == int'(i_delay))
         begin
            o_vector_ack <= 1'h1;
            wait_n <= wait_n + 1;
         end
         else if (wait_n < 16)
            wait_n <= wait_n + 1;
      end
   end
endmodule
`default_nettype wire

/* sim/tb_atrc_top.sv */
// self-checking bench of the converter trigger and result control block
`timescale 1ns/1ps
`default_nettype none
module tb_atrc_top;
   logic        clk = 1'h0, rstn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
   logic        glob = 1'h0, serve = 1'h0, ack, irq, vack, busy, cken;
   logic [3:0]  sel = 4'h1;
   logic [9:0]  adr = 10'h000, cres = 10'h000;
   logic [31:0] wdat = 32'h0, rdat;
   logic [6:0]  trig = 7'h00;
   logic [7:0]  praw = 8'h00, poff, pread, d;
   logic [4:0]  chan;
   logic [1:0]  refs;
   logic [7:0]  regs [6] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7e};
   int          n_mismatch = 0, num_checks = 0, seed = 52;
   // reference model of the result path
   int          res = 0, locked = 0, left = 0, first = 1, div;

   // system clock, 8 ns period
   always #4 clk = ~clk;

   atrc_top atrc_top_i
   (
      .i_clk                    (clk),
      .i_rstn                   (rstn),
      .i_wb_cyc                 (cyc),
      .i_wb_stb                 (stb),
      .i_wb_we                  (we),
      .i_wb_adr                 (adr),
      .i_wb_sel                 (sel),
      .i_wb_dat                 (wdat),
      .o_wb_dat                 (rdat),
      .o_wb_ack                 (ack),
      .i_trigger_flags          (trig),
      .i_global_irq_enable      (glob),
      .i_irq_vector_ack         (vack),
      .o_irq_request            (irq),
      .i_conv_result            (cres),
      .o_conv_busy              (busy),
      .o_conv_clk_en            (cken),
      .o_input_channel_select   (chan),
      .o_reference_select       (refs),
      .i_pin_raw                (praw),
      .o_pin_digital_buffer_off (poff),
      .o_pin_read               (pread)
   );

   atrc_core_model atrc_core_model_i
   (
      .i_clk         (clk),
      .i_rstn        (rstn),
      .i_irq_request (irq),
      .i_serve       (serve),
      .i_delay       (4'h5),
      .o_vector_ack  (vack)
   );

   // ----------------------------------------
   // compare, bus and conversion tasks
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one classic cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] dw,
                     output logic [31:0] v);
      int t;
      t = 0;
      @(posedge clk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= {idx, 2'h0};
      wdat <= {24'h0, dw};
      do
      begin
         @(posedge clk);
         t++;
      end
      while (ack !== 1'h1 && t < 50);
      v = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
      chk("bus ack", 1, t < 50);
      if (!w && idx == 8'h78)
         locked = 1;
      if (!w && idx == 8'h79)
         locked = 0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] dw);
      logic [31:0] v;
      wb(1'h1, idx, dw, v);
      if (idx == 8'h7a && !dw[7])
         first = 1;
      if (idx == 8'h7c)
         left = dw[5];
   endtask

   task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] v;
      wb(1'h0, idx, 8'h00, v);
      chk(name, {24'h0, e}, v);
   endtask

   function automatic logic [7:0] lo();
      return (left != 0) ? {res[1:0], 6'h00} : res[7:0];
   endfunction

   function automatic logic [7:0] hi();
      return (left != 0) ? res[9:2] : {6'h00, res[9:8]};
   endfunction

   // follow one conversion; ncyc 0 skips the length checks
   task automatic wait_conv(input int ncyc);
      int n, p;
      n = 0;
      p = 0;
      for (int t = 0; t < 20000; t++)
      begin
         @(posedge clk);
         #1;
         if (cken === 1'h1)
            p++;
         if (busy === 1'h1)
            n++;
         else if (n > 0)
            break;
      end
      chk("busy seen", 1, n > 0);
      if (ncyc > 0)
      begin
         chk("tick count", ncyc, p);
         chk("conv length", 1, n >= ncyc * div - 2 && n <= ncyc * div + div + 2);
      end
      first = 0;
      if (locked == 0)
         res = cres;
   endtask

   task automatic conv(input logic [7:0] ctrl);
      int n;
      n = (first != 0) ? 25 : 13;
      cres <= 10'($random(seed));
      wr(8'h7a, ctrl);
      wait_conv(n);
   endtask

   task automatic quiet(input string name);
      for (int t = 0; t < 8; t++)
      begin
         @(posedge clk);
         #1;
         chk(name, 0, busy);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (6) @(posedge clk);
      rstn <= 1'h1;
      foreach (regs[i])
         rd_chk("reset value", regs[i], 8'h00);
      wr(8'h10, 8'hff);
      rd_chk("unmapped", 8'h10, 8'h00);
      $display("test reset finished");
      d = 8'($random(seed));
      wr(8'h7e, d);
      praw <= 8'($random(seed));
      repeat (5) @(posedge clk);
      chk("pin read", {24'h0, praw & ~d}, pread);
      chk("buffer off", d, poff);
      rd_chk("input disable", 8'h7e, d);
      $display("test pins finished");
      // every divider code, alternating alignment
      for (int c = 0; c < 8; c++)
      begin
         div = (c < 2) ? 2 : (1 << c);
         wr(8'h7c, {2'h0, c[0], 5'h00});
         conv(8'hd0 | 8'(c));
         rd_chk("ctrl a done", 8'h7a, 8'h90 | 8'(c));
         rd_chk("low byte", 8'h78, lo());
         rd_chk("high byte", 8'h79, hi());
      end
      $display("test divider finished");
      div = 2;
      rd_chk("low byte", 8'h78, lo());
      cres <= 10'($random(seed));
      wr(8'h7a, 8'hd0);
      rd_chk("start reads busy", 8'h7a, 8'hc0);
      wr(8'h7c, 8'hdf);
      chk("select held", 8'h00, {refs, chan});
      wait_conv(0);
      repeat (2) @(posedge clk);
      chk("select new", {25'h0, 2'h3, 5'h1f}, {refs, chan});
      rd_chk("high locked", 8'h79, hi());
      rd_chk("low locked", 8'h78, lo());
      rd_chk("high locked", 8'h79, hi());
      rd_chk("flag kept", 8'h7a, 8'h90);
      $display("test lock finished");
      wr(8'h7a, 8'h88);
      #1;
      chk("irq masked", 0, irq);
      glob <= 1'h1;
      @(posedge clk);
      #1;
      chk("irq raised", 1, irq);
      rd_chk("flag after write 0", 8'h7a, 8'h98);
      serve <= 1'h1;
      repeat (10) @(posedge clk);
      serve <= 1'h0;
      rd_chk("flag after vector", 8'h7a, 8'h88);
      conv(8'hc8);
      wr(8'h7a, 8'h98);
      rd_chk("flag after write 1", 8'h7a, 8'h88);
      chk("irq dropped", 0, irq);
      glob <= 1'h0;
      $display("test interrupt finished");
      wr(8'h7b, 8'h03);
      wr(8'h7a, 8'h90);
      trig <= 7'h04;
      quiet("no auto trigger");
      trig <= 7'h00;
      for (int c = 1; c < 8; c++)
      begin
         wr(8'h7b, 8'(c));
         wr(8'h7a, 8'hb0);
         trig <= 7'(1 << (c - 1));
         wait_conv(13);
         trig <= 7'h00;
         rd_chk("auto flag", 8'h7a, 8'hb0);
      end
      wr(8'h7b, 8'h01);
      trig <= 7'h02;
      wr(8'h7b, 8'h02);
      wait_conv(13);
      trig <= 7'h00;
      wr(8'h7b, 8'h00);
      quiet("free run select");
      wr(8'h7a, 8'he0);
      wait_conv(13);
      repeat (2) @(posedge clk);
      #1;
      chk("free run restart", 1, busy);
      wr(8'h7a, 8'h10);
      repeat (2) @(posedge clk);
      #1;
      chk("abort busy", 0, busy);
      repeat (40) @(posedge clk);
      rd_chk("abort no flag", 8'h7a, 8'h00);
      conv(8'hc0);
      $display("test auto trigger finished");
      test_done();
   end

   // hang guard, far beyond the expected run
   initial
   begin
      #400000;
      n_mismatch++;
      test_done();
   end
endmodule
`default_nettype wire
